//--- stoseq_pkg.sv
// Package with constants, register map and state encoding of the safe-off sequencer.
package stoseq_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned HOLD_MS         = 20;
    // Strictly more than the hold time, in whole processing ticks.
    localparam int unsigned HOLD_TICKS      = HOLD_MS / TICK_MS + 1;
    localparam int unsigned DISC_MS         = 100;
    localparam int unsigned DEB_CYCLES      = 16;
    localparam int unsigned LEAD_MS         = 0;

    // ========================================================================
    // Register map (byte addresses)
    // ========================================================================
    localparam logic [7:0] ADDR_BRAKE_DLY   = 8'h00;
    localparam logic [7:0] ADDR_DISC_TIME   = 8'h04;
    localparam logic [7:0] ADDR_STATUS      = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT    = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h10;

    // Reset values.
    localparam logic [7:0] BRAKE_MIN_TICKS  = 8'h05;
    localparam logic [7:0] DISC_RST_TICKS   = 8'(DISC_MS / TICK_MS);
    localparam logic [3:0] IRQ_MASK_RST     = 4'h0;

    // Interrupt bit positions.
    localparam int unsigned IRQ_STAGE_ERR   = 0;
    localparam int unsigned IRQ_DISC_ERR    = 1;
    localparam int unsigned IRQ_SAFE_OFF    = 2;
    localparam int unsigned IRQ_RUN         = 3;

    // Status bit positions.
    localparam int unsigned ST_BIT_ENABLE   = 0;
    localparam int unsigned ST_BIT_FIRST    = 1;
    localparam int unsigned ST_BIT_SECOND   = 2;
    localparam int unsigned ST_BIT_STAGE    = 3;
    localparam int unsigned ST_BIT_BRAKE    = 4;
    localparam int unsigned ST_BIT_SETPT    = 5;
    localparam int unsigned ST_BIT_FEEDBK   = 6;
    localparam int unsigned ST_BIT_STATE    = 8;

    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // ========================================================================
    // Sequencer states
    // ========================================================================
    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_HOLD  = 5'h02,
        ST_READY = 5'h04,
        ST_BRAKE = 5'h08,
        ST_RUN   = 5'h10
    } stoseq_state_t;

endpackage

//--- stoseq_sync_deb.sv
// Two-flop synchroniser and debounce filter for the three control pins.
`timescale 1ns/1ps
module stoseq_sync_deb (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Raw pins and filtered levels
    input  wire logic [2:0] pin_raw,
    output logic      [2:0] pin_clean
);

    // ========================================================================
    // One filter per pin
    // ========================================================================
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            logic       meta_ff;
            logic       sync_ff;
            logic       stable_ff;
            logic [4:0] cnt_ff;

            // The first flop feeds only the second one.
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= pin_raw[g];
                    sync_ff <= meta_ff;
                end
            end

            // A level must persist for the whole debounce span before it is taken.
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_ff    <= 5'h00;
                    stable_ff <= 1'b0;
                end else if (sync_ff == stable_ff) begin
                    cnt_ff <= 5'h00;
                end else if (cnt_ff == 5'(stoseq_pkg::DEB_CYCLES - 1)) begin
                    cnt_ff    <= 5'h00;
                    stable_ff <= sync_ff;
                end else begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
            end

            assign pin_clean[g] = stable_ff;
        end
    endgenerate

endmodule

//--- stoseq_tick.sv
// Processing-cycle pulse generator.
`timescale 1ns/1ps
module stoseq_tick #(
    parameter int unsigned TICK_CYCLES = stoseq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // One-cycle pulse per processing cycle
    output logic      tick
);

    logic [31:0] cnt_ff;
    logic        tick_ff;

    // ========================================================================
    // Free-running divider
    // ========================================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff == 32'(TICK_CYCLES - 1)) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule

//--- stoseq_top.sv
// Safe-off restart sequencer with AXI4-Lite register access.
// Operation
// - Both safe-off channels are handled identically, so their switching order does not matter.
// - A change of the safe-off inputs is reflected in the sequencer within one 10 ms cycle.
// - The motion setpoint is applied only after the brake release delay has fully elapsed.
// - Dropping a safe-off input while the output stage is active raises an error.
// - The holding brake is driven by ordinary drive logic and engages after safe-off.
// - The brake release delay is configurable and never below the physical opening time.
// - The feedback contact closes after safe-off takes effect and opens after release.
// - The feedback contact is closed only while both channels were off at the last processing tick.
// - Channel states are compared every 10 ms and a lasting mismatch is an error.
// - Mismatches are tolerated for a default discrepancy time of 100 ms.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module stoseq_top #(
    parameter int unsigned TICK_CYCLES = stoseq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control pins
    input  wire logic        safe_off_input_first,
    input  wire logic        safe_off_input_second,
    input  wire logic        output_stage_enable_input,
    // Drive outputs
    output logic             stage_enable,
    output logic             brake_release,
    output logic             setpoint_enable,
    output logic             feedback_contact,
    output logic             irq,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ========================================================================
    // Declarations
    // ========================================================================
    stoseq_pkg::stoseq_state_t state_ff;
    stoseq_pkg::stoseq_state_t nxt_state;

    logic [2:0]  pin_clean;
    logic        tick;
    logic        in_first;
    logic        in_second;
    logic        in_enable;
    logic        both_on;
    logic        both_off;
    logic [7:0]  seq_cnt_ff;
    logic [7:0]  nxt_seq_cnt;
    logic [7:0]  disc_cnt_ff;
    logic [7:0]  brake_dly_ff;
    logic [7:0]  disc_time_ff;
    logic [3:0]  irq_stat_ff;
    logic [3:0]  irq_mask_ff;
    logic [3:0]  irq_set;
    logic        stage_ff;
    logic        brake_ff;
    logic        setpt_ff;
    logic        feedbk_ff;
    logic        aw_held_ff;
    logic [7:0]  aw_addr_ff;
    logic        w_held_ff;
    logic [31:0] w_data_ff;
    logic        w_lane0_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;
    logic        do_write;
    logic        wr_lane0;
    logic [31:0] status_word;

    // Address decode shared by the read and the write path.
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == stoseq_pkg::ADDR_BRAKE_DLY) ||
                  (addr == stoseq_pkg::ADDR_DISC_TIME) ||
                  (addr == stoseq_pkg::ADDR_STATUS)    ||
                  (addr == stoseq_pkg::ADDR_IRQ_STAT)  ||
                  (addr == stoseq_pkg::ADDR_IRQ_MASK);
    endfunction

    // ========================================================================
    // Pin conditioning and processing tick
    // ========================================================================
    stoseq_sync_deb u_sync_deb (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_raw   ({output_stage_enable_input, safe_off_input_second,
                     safe_off_input_first}),
        .pin_clean (pin_clean)
    );

    stoseq_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick)
    );

    assign in_first  = pin_clean[0];
    assign in_second = pin_clean[1];
    assign in_enable = pin_clean[2];
    // Symmetric combinations, so neither channel has precedence.
    assign both_on   = in_first & in_second;
    assign both_off  = ~(in_first | in_second);

    // ========================================================================
    // Sequencer
    // ========================================================================
    // Loss of a channel or of the enable acts at once, so a dip shorter than a
    // tick still drops the stage at once; the restart steps advance on ticks only.
    always_comb begin
        nxt_state   = state_ff;
        nxt_seq_cnt = seq_cnt_ff;
        if (!both_on) begin
            nxt_state   = stoseq_pkg::ST_OFF;
            nxt_seq_cnt = 8'h00;
        end else if (!in_enable && (state_ff == stoseq_pkg::ST_BRAKE ||
                                    state_ff == stoseq_pkg::ST_RUN)) begin
            nxt_state = stoseq_pkg::ST_READY;
        end else if (tick) begin
            unique case (state_ff)
                stoseq_pkg::ST_OFF: begin
                    nxt_state   = stoseq_pkg::ST_HOLD;
                    nxt_seq_cnt = 8'h00;
                end
                stoseq_pkg::ST_HOLD: begin
                    // A high enable restarts the low-time count.
                    if (in_enable) begin
                        nxt_seq_cnt = 8'h00;
                    end else if (seq_cnt_ff == 8'(stoseq_pkg::HOLD_TICKS - 1)) begin
                        nxt_state   = stoseq_pkg::ST_READY;
                        nxt_seq_cnt = 8'h00;
                    end else begin
                        nxt_seq_cnt = seq_cnt_ff + 8'h01;
                    end
                end
                stoseq_pkg::ST_READY: begin
                    if (in_enable) begin
                        nxt_state   = stoseq_pkg::ST_BRAKE;
                        nxt_seq_cnt = 8'h00;
                    end
                end
                stoseq_pkg::ST_BRAKE: begin
                    if (seq_cnt_ff >= brake_dly_ff - 8'h01) begin
                        nxt_state = stoseq_pkg::ST_RUN;
                    end else begin
                        nxt_seq_cnt = seq_cnt_ff + 8'h01;
                    end
                end
                stoseq_pkg::ST_RUN: begin
                    // Left only through a channel or enable loss above.
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= stoseq_pkg::ST_OFF;
            seq_cnt_ff <= 8'h00;
        end else begin
            state_ff   <= nxt_state;
            seq_cnt_ff <= nxt_seq_cnt;
        end
    end

    // ========================================================================
    // Drive outputs
    // ========================================================================
    // Stage and brake drop at once when a channel goes off, without waiting for
    // the tick; the sequencer leaves the run states in that same cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_ff <= 1'b0;
            brake_ff <= 1'b0;
            setpt_ff <= 1'b0;
        end else begin
            stage_ff <= both_on & in_enable &
                        (state_ff == stoseq_pkg::ST_BRAKE || state_ff == stoseq_pkg::ST_RUN);
            brake_ff <= both_on & in_enable &
                        (state_ff == stoseq_pkg::ST_BRAKE ||
                         state_ff == stoseq_pkg::ST_RUN);
            setpt_ff <= both_on & in_enable & (state_ff == stoseq_pkg::ST_RUN);
        end
    end

    // The contact follows the channels on the processing tick only.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            feedbk_ff <= 1'b0;
        end else if (tick) begin
            feedbk_ff <= both_off;
        end
    end

    assign stage_enable     = stage_ff;
    assign brake_release    = brake_ff;
    assign setpoint_enable  = setpt_ff;
    assign feedback_contact = feedbk_ff;

    // ========================================================================
    // Discrepancy supervision
    // ========================================================================
    // Counts ticks of mismatch and saturates one past the limit.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disc_cnt_ff <= 8'h00;
        end else if (tick) begin
            if (in_first == in_second) begin
                disc_cnt_ff <= 8'h00;
            end else if (disc_cnt_ff <= disc_time_ff) begin
                disc_cnt_ff <= disc_cnt_ff + 8'h01;
            end
        end
    end

    // ========================================================================
    // Interrupt events
    // ========================================================================
    always_comb begin
        irq_set = 4'h0;
        irq_set[stoseq_pkg::IRQ_STAGE_ERR] = stage_ff & ~both_on;
        irq_set[stoseq_pkg::IRQ_DISC_ERR]  = tick & (in_first != in_second) &
                                             (disc_cnt_ff == disc_time_ff);
        irq_set[stoseq_pkg::IRQ_SAFE_OFF]  = (nxt_state == stoseq_pkg::ST_OFF) &
                                             (state_ff != stoseq_pkg::ST_OFF);
        irq_set[stoseq_pkg::IRQ_RUN]       = (nxt_state == stoseq_pkg::ST_RUN) &
                                             (state_ff != stoseq_pkg::ST_RUN);
    end

    assign wr_lane0 = do_write & w_lane0_ff;

    // Sticky bits; a new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_ff <= 4'h0;
        end else if (wr_lane0 && aw_addr_ff == stoseq_pkg::ADDR_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~w_data_ff[3:0]) | irq_set;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ========================================================================
    // Configuration registers
    // ========================================================================
    // The brake delay is clamped so it can never undercut the opening time.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            brake_dly_ff <= stoseq_pkg::BRAKE_MIN_TICKS;
        end else if (wr_lane0 && aw_addr_ff == stoseq_pkg::ADDR_BRAKE_DLY) begin
            brake_dly_ff <= (w_data_ff[7:0] < stoseq_pkg::BRAKE_MIN_TICKS) ?
                            stoseq_pkg::BRAKE_MIN_TICKS : w_data_ff[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disc_time_ff <= stoseq_pkg::DISC_RST_TICKS;
        end else if (wr_lane0 && aw_addr_ff == stoseq_pkg::ADDR_DISC_TIME) begin
            disc_time_ff <= w_data_ff[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_ff <= stoseq_pkg::IRQ_MASK_RST;
        end else if (wr_lane0 && aw_addr_ff == stoseq_pkg::ADDR_IRQ_MASK) begin
            irq_mask_ff <= w_data_ff[3:0];
        end
    end

    // ========================================================================
    // AXI4-Lite write channel
    // ========================================================================
    // Address and data are caught independently; the write fires once both are in.
    assign s_axi_awready = ~aw_held_ff;
    assign s_axi_wready  = ~w_held_ff;
    assign do_write      = aw_held_ff & w_held_ff & ~bvalid_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
        end else if (s_axi_awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_lane0_ff <= 1'b0;
        end else if (s_axi_wvalid && !w_held_ff) begin
            w_held_ff  <= 1'b1;
            w_data_ff  <= s_axi_wdata;
            w_lane0_ff <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= stoseq_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= reg_hit(aw_addr_ff) ? stoseq_pkg::RESP_OKAY : stoseq_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ========================================================================
    // AXI4-Lite read channel
    // ========================================================================
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[stoseq_pkg::ST_BIT_ENABLE] = in_enable;
        status_word[stoseq_pkg::ST_BIT_FIRST]  = in_first;
        status_word[stoseq_pkg::ST_BIT_SECOND] = in_second;
        status_word[stoseq_pkg::ST_BIT_STAGE]  = stage_ff;
        status_word[stoseq_pkg::ST_BIT_BRAKE]  = brake_ff;
        status_word[stoseq_pkg::ST_BIT_SETPT]  = setpt_ff;
        status_word[stoseq_pkg::ST_BIT_FEEDBK] = feedbk_ff;
        status_word[stoseq_pkg::ST_BIT_STATE +: 5] = state_ff;
    end

    assign s_axi_arready = ~rvalid_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= stoseq_pkg::RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= reg_hit(s_axi_araddr) ? stoseq_pkg::RESP_OKAY : stoseq_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                stoseq_pkg::ADDR_BRAKE_DLY: rdata_ff <= {24'h00_0000, brake_dly_ff};
                stoseq_pkg::ADDR_DISC_TIME: rdata_ff <= {24'h00_0000, disc_time_ff};
                stoseq_pkg::ADDR_STATUS:    rdata_ff <= status_word;
                stoseq_pkg::ADDR_IRQ_STAT:  rdata_ff <= {28'h000_0000, irq_stat_ff};
                stoseq_pkg::ADDR_IRQ_MASK:  rdata_ff <= {28'h000_0000, irq_mask_ff};
                default:                    rdata_ff <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;

endmodule

//--- stoseq_props.sv
// Concurrent checks on the sequencer pins and bus.
`timescale 1ns/1ps
module stoseq_props #(
    parameter int unsigned TICK_CYCLES = 50
) (
    // Clock, reset and pins
    input wire logic clk,
    input wire logic arst_n,
    input wire logic safe_off_input_first,
    input wire logic safe_off_input_second,
    input wire logic output_stage_enable_input,
    // Drive outputs and bus
    input wire logic stage_enable,
    input wire logic brake_release,
    input wire logic setpoint_enable,
    input wire logic feedback_contact,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    // One domain, so clock and reset are given once.
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_first_stops: assert property ($fell(safe_off_input_first) |-> ##[1:25] !stage_enable)
        else $error("stage on after first channel fell");
    a_second_stops: assert property ($fell(safe_off_input_second) |-> ##[1:25] !stage_enable)
        else $error("stage on after second channel fell");
    a_brake_engages: assert property ($fell(safe_off_input_second) |-> ##[1:25] !brake_release)
        else $error("brake open after channel fell");
    a_contact_both_low: assert property ($rose(feedback_contact) |->
        !safe_off_input_first && !safe_off_input_second)
        else $error("contact closed with a channel high");
    a_stage_needs_en: assert property ($rose(stage_enable) |-> output_stage_enable_input)
        else $error("stage on without enable");
    a_brake_delay: assert property ($rose(stage_enable) |=> !setpoint_enable [*8])
        else $error("setpoint before brake delay");
    a_setpt_stage: assert property (setpoint_enable |-> stage_enable && brake_release)
        else $error("setpoint without stage");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule
bind stoseq_top stoseq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk, .arst_n,
    .safe_off_input_first, .safe_off_input_second, .output_stage_enable_input, .stage_enable,
    .brake_release, .setpoint_enable, .feedback_contact, .s_axi_bvalid, .s_axi_bready);

//--- stoseq_partner.sv
// Safety switching device model driving both channels and the enable.
`timescale 1ns/1ps
module stoseq_partner #(
    parameter int HOLD = 260
) (
    // Clock and pins
    input  wire logic clk,
    output logic      ch_a,
    output logic      ch_b,
    output logic      en
);
    initial {ch_a, ch_b, en} = 3'h0;
    // Enable is low before the channels return and long after, so no restart races.
    task automatic restart();
        @(posedge clk);
        en <= 1'h0;
        @(posedge clk);
        {ch_a, ch_b} <= 2'h3;
        repeat (HOLD) @(posedge clk);
        en <= 1'h1;
    endtask
    // Opens one channel only, leaving a skew until the other follows.
    task automatic drop(input bit second);
        @(posedge clk);
        if (second) ch_b <= 1'h0;
        else ch_a <= 1'h0;
    endtask
endmodule

//--- testbench.sv
// Self-checking bench for the safe-off sequencer.
`timescale 1ns/1ps
module testbench;
    logic        clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, stage_enable, brake_release, setpoint_enable;
    logic        feedback_contact, irq;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire         p_a, p_b, p_en;
    int          err_total = 0, compares = 0, cyc = 0, n;
    stoseq_top #(.TICK_CYCLES(50)) dut (.clk, .arst_n, .safe_off_input_first(p_a),
        .safe_off_input_second(p_b), .output_stage_enable_input(p_en), .stage_enable,
        .brake_release, .setpoint_enable, .feedback_contact, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    stoseq_partner pt (.clk, .ch_a(p_a), .ch_b(p_b), .en(p_en));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write: each channel drops when taken; bready rises once bvalid is seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        repeat (20) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h1;
        @(posedge clk);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rs);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        repeat (20) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, rs);
    endtask
    task automatic wait_hi(input bit sp, output int k);
        for (k = 0; k < 700; k++) begin
            @(posedge clk);
            if ((sp ? setpoint_enable : stage_enable) === 1'h1) break;
        end
    endtask
    // Full restart, then the stage-to-setpoint gap is measured in cycles.
    task automatic restart(input int dly);
        pt.restart();
        wait_hi(0, n);
        chk({stage_enable, brake_release, setpoint_enable}, 32'h6);
        wait_hi(1, n);
        chk(n inside {[dly * 50 - 2 : dly * 50 + 50]}, 32'h1);
    endtask
    task automatic report_and_stop();
        $display("Compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // A hang counts as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'h1;
        rd(8'h00, 32'h5, 2'h0);
        rd(8'h04, 32'hA, 2'h0);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h10, 32'h2);
        restart(5);
        pt.drop(1'h1);
        repeat (25) @(posedge clk);
        chk(stage_enable, 32'h0);
        repeat (450) @(posedge clk);
        chk({feedback_contact, irq}, 32'h0);
        repeat (150) @(posedge clk);
        rd(8'h0C, 32'hF, 2'h0);
        chk(irq, 32'h1);
        pt.drop(1'h0);
        repeat (80) @(posedge clk);
        chk(feedback_contact, 32'h1);
        rd(8'h08, 32'h141, 2'h0);
        wr(8'h0C, 32'hF);
        chk(irq, 32'h0);
        wr(8'h00, 32'h2);
        rd(8'h00, 32'h5, 2'h0);
        wr(8'h00, 32'h7);
        restart(7);
        chk(feedback_contact, 32'h0);
        pt.drop(1'h0);
        repeat (25) @(posedge clk);
        chk(stage_enable, 32'h0);
        report_and_stop();
    end
endmodule
